/* hw/drive_status_params.svh */
/*
 * Offsets, field positions, reset values and timing counts for the
 * drive status output block. Assumes a Wishbone slave with 32-bit data.
 */
`ifndef DRIVE_STATUS_PARAMS_SVH
`define DRIVE_STATUS_PARAMS_SVH

// Register byte offsets
`define ADDR_START_FREQ   8'h00
`define ADDR_DETECT_FREQ  8'h04
`define ADDR_BAND_PCT     8'h08
`define ADDR_CONFIG       8'h0C
`define ADDR_FLAGS        8'h10
`define ADDR_IRQ_STATUS   8'h14
`define ADDR_IRQ_MASK     8'h18

// Config fields
`define CFG_METER_SEL_BIT 0
`define CFG_OC_PULSE_BIT  1

// Reset values, frequencies in 0.01 Hz units
`define RST_START_FREQ    16'h0032
`define RST_DETECT_FREQ   16'h1770
`define RST_BAND_PCT      8'h0A
`define RST_CONFIG        2'h0

// Event bits of the interrupt status register
`define EVT_FAULT         0
`define EVT_POWER_FAIL    1
`define EVT_OVERLOAD      2
`define EVT_FREQ_DETECT   3
`define EVT_W             4

// Meter scaling and clock
`define CLK_HZ            125000000
`define METER_REF_HZ      60
`define FREQ_UNITS_PER_HZ 100
`define OC_MAX_PPS        50000

`endif

/* hw/drive_status_pkg.sv */
/*
 * Types shared by the drive status output block.
 * Assumes frequencies arrive in 0.01 Hz units, 16 bits wide.
 */
package drive_status_pkg;

    typedef struct packed {
        logic [15:0] out_freq;
        logic [15:0] set_freq;
        logic        accel;
        logic        decel;
        logic        stopped;
        logic        dc_brake;
        logic        stall_active;
        logic        inst_power_fail;
        logic        undervoltage;
        logic        prot_tripped;
        logic        output_off;
        logic        drive_reset;
    } drive_state_type;

    typedef struct packed {
        logic fault;
        logic freq_detect;
        logic power_fail;
        logic overload;
        logic up_to_speed;
        logic running;
    } status_flags_type;

endpackage : drive_status_pkg

/* hw/drive_status_outputs.sv */
/*
 * Status output logic of a motor drive: open-collector flags, fault
 * changeover relay, meter pulse train, Wishbone registers and interrupt.
 * Assumes drive state inputs synchronous to clk_i, frequencies in 0.01 Hz.
 */
// Register access over Wishbone and the placing of the registers were left to the implementer.
// Contract
// RULE1: Relay goes to fault position when protection tripped and output stopped.
// RULE2: Fault opens normally-closed path, closes normally-open; healthy is opposite.
// RULE3: Running flag asserts when output frequency reaches starting frequency, default 0.5 Hz.
// RULE4: Running flag deasserts while stopped or during DC injection braking.
// RULE5: Up-to-speed asserts inside configurable band around set frequency, default 10 percent.
// RULE6: Up-to-speed stays off during acceleration, deceleration and stop.
// RULE7: Overload warning follows stall prevention being active.
// RULE8: Power-failure flag asserts on instantaneous power failure or undervoltage.
// RULE9: Frequency-detection flag follows output frequency against programmable threshold.
// RULE10: Open-collector flag low means transistor conducting, high means off.
// RULE11: Meter pulse rate proportional to selected item, 60 Hz gives 1440 pulses/s.
// RULE12: Meter pulse output is suppressed while drive reset is in progress.
// RULE13: Open-collector pulse mode limits output to 50 kilopulses per second.
// RULE14: Flags evaluated each cycle, registered, no extra filtering or hysteresis.
`timescale 1ns/1ps
`include "drive_status_params.svh"

module drive_status_outputs
    import drive_status_pkg::*;
#(
    parameter int PULSES_AT_REF = 1440
) (
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire drive_state_type drive_i,
    input  wire logic            cyc_i,
    input  wire logic            stb_i,
    input  wire logic            we_i,
    input  wire logic [7:0]      adr_i,
    input  wire logic [3:0]      sel_i,
    input  wire logic [31:0]     dat_i,
    output logic [31:0]          dat_o,
    output logic                 ack_o,
    output logic                 irq_o,
    output logic                 running_flag_n_o,
    output logic                 up_to_speed_flag_n_o,
    output logic                 overload_warning_flag_n_o,
    output logic                 power_failure_flag_n_o,
    output logic                 freq_detect_flag_n_o,
    output logic                 fault_relay_no_contact_o,
    output logic                 fault_relay_nc_contact_o,
    output logic                 meter_pulse_out_o
);

    localparam logic [29:0] TOGGLE_STEP = 30'(2 * PULSES_AT_REF);
    localparam logic [39:0] METER_WRAP  =
        40'(64'(`METER_REF_HZ) * `FREQ_UNITS_PER_HZ * `CLK_HZ);
    // Open-collector stage is slow: cap the toggle increment
    localparam logic [39:0] OC_MAX_INC  =
        40'(64'(2) * `OC_MAX_PPS * `METER_REF_HZ * `FREQ_UNITS_PER_HZ);

    // Register group
    logic [15:0]         start_freq_reg, start_freq_next;
    logic [15:0]         detect_freq_reg, detect_freq_next;
    logic [7:0]          band_pct_reg, band_pct_next;
    logic [1:0]          config_reg, config_next;
    logic [`EVT_W-1:0]   irq_status_reg, irq_status_next;
    logic [`EVT_W-1:0]   irq_mask_reg, irq_mask_next;
    logic [31:0]         rdata_reg, rdata_next;
    logic                ack_reg, ack_next;
    logic                irq_reg, irq_next;

    // Flag group
    status_flags_type    flags_reg, flags_next;
    logic [`EVT_W-1:0]   events;

    // Pin stage: active-low copies in their own flops, no gate after them
    logic [4:0]          pins_n_reg, pins_n_next;
    logic                relay_nc_reg, relay_nc_next;

    // Meter group
    logic [39:0]         meter_acc_reg, meter_acc_next;
    logic                meter_reg, meter_next;

    logic [16:0]         freq_diff;
    logic [23:0]         diff_scaled;
    logic [23:0]         band_limit;
    logic [39:0]         meter_inc;
    logic [39:0]         meter_sum;
    logic                bus_req;

    assign bus_req = cyc_i && stb_i && !ack_reg;

    always_comb begin
        freq_diff   = (drive_i.out_freq >= drive_i.set_freq) ?
                      {1'b0, drive_i.out_freq - drive_i.set_freq} :
                      {1'b0, drive_i.set_freq - drive_i.out_freq};
        diff_scaled = 24'(freq_diff * 24'd100);
        // Sized operands: a 16-bit product would wrap for wide bands
        band_limit  = 24'(drive_i.set_freq) * 24'(band_pct_reg);
        flags_next  = '0;
        flags_next.running = (drive_i.out_freq >= start_freq_reg)       // [RULE3]
                             && !drive_i.stopped && !drive_i.dc_brake;  // [RULE4]
        flags_next.up_to_speed = (diff_scaled <= band_limit)            // [RULE5]
                                 && !drive_i.accel && !drive_i.decel
                                 && !drive_i.stopped;                   // [RULE6]
        flags_next.overload    = drive_i.stall_active;                  // [RULE7]
        flags_next.power_fail  = drive_i.inst_power_fail
                                 || drive_i.undervoltage;               // [RULE8]
        flags_next.freq_detect = drive_i.out_freq >= detect_freq_reg;   // [RULE9]
        flags_next.fault       = drive_i.prot_tripped
                                 && drive_i.output_off;                 // [RULE1]
        pins_n_next   = ~{flags_next.freq_detect, flags_next.power_fail,
                          flags_next.overload, flags_next.up_to_speed,
                          flags_next.running};                          // [RULE10]
        relay_nc_next = !flags_next.fault;                              // [RULE2]
    end

    // Same edge as flags_reg, so pins and status register never disagree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pins_n_reg   <= 5'h1F;
            relay_nc_reg <= 1'b1;
        end else begin
            pins_n_reg   <= pins_n_next;
            relay_nc_reg <= relay_nc_next;
        end
    end

    // No filtering: one register stage per flag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= flags_next;                                    // [RULE14]
        end
    end

    // Rising edges of the fault, power-fail, overload and freq-detect flags raise events
    assign events[`EVT_FAULT]       = flags_next.fault && !flags_reg.fault;
    assign events[`EVT_POWER_FAIL]  = flags_next.power_fail && !flags_reg.power_fail;
    assign events[`EVT_OVERLOAD]    = flags_next.overload && !flags_reg.overload;
    assign events[`EVT_FREQ_DETECT] = flags_next.freq_detect && !flags_reg.freq_detect;

    always_comb begin
        start_freq_next  = start_freq_reg;
        detect_freq_next = detect_freq_reg;
        band_pct_next    = band_pct_reg;
        config_next      = config_reg;
        irq_mask_next    = irq_mask_reg;
        irq_status_next  = irq_status_reg;
        rdata_next       = 32'h0000_0000;
        ack_next         = bus_req;
        if (bus_req && we_i) begin
            case (adr_i)
                `ADDR_START_FREQ: begin
                    if (sel_i[0]) start_freq_next[7:0]  = dat_i[7:0];
                    if (sel_i[1]) start_freq_next[15:8] = dat_i[15:8];
                end
                `ADDR_DETECT_FREQ: begin
                    if (sel_i[0]) detect_freq_next[7:0]  = dat_i[7:0];
                    if (sel_i[1]) detect_freq_next[15:8] = dat_i[15:8];
                end
                `ADDR_BAND_PCT: begin
                    if (sel_i[0]) band_pct_next = dat_i[7:0];
                end
                `ADDR_CONFIG: begin
                    if (sel_i[0]) config_next = dat_i[1:0];
                end
                `ADDR_IRQ_STATUS: begin
                    if (sel_i[0]) irq_status_next = irq_status_reg & ~dat_i[`EVT_W-1:0];
                end
                `ADDR_IRQ_MASK: begin
                    if (sel_i[0]) irq_mask_next = dat_i[`EVT_W-1:0];
                end
                default: begin
                end
            endcase
        end else if (bus_req) begin
            case (adr_i)
                `ADDR_START_FREQ:  rdata_next = {16'h0000, start_freq_reg};
                `ADDR_DETECT_FREQ: rdata_next = {16'h0000, detect_freq_reg};
                `ADDR_BAND_PCT:    rdata_next = {24'h000000, band_pct_reg};
                `ADDR_CONFIG:      rdata_next = {30'h0000_0000, config_reg};
                `ADDR_FLAGS:       rdata_next = {26'h000_0000, flags_reg};
                `ADDR_IRQ_STATUS:  rdata_next = {28'h000_0000, irq_status_reg};
                `ADDR_IRQ_MASK:    rdata_next = {28'h000_0000, irq_mask_reg};
                default:           rdata_next = 32'h0000_0000;
            endcase
        end
        // Set wins over a same-cycle clear
        irq_status_next = irq_status_next | events;
        irq_next        = |(irq_status_next & irq_mask_next);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            start_freq_reg  <= `RST_START_FREQ;
            detect_freq_reg <= `RST_DETECT_FREQ;
            band_pct_reg    <= `RST_BAND_PCT;
            config_reg      <= `RST_CONFIG;
            irq_status_reg  <= '0;
            irq_mask_reg    <= '0;
            rdata_reg       <= 32'h0000_0000;
            ack_reg         <= 1'b0;
            irq_reg         <= 1'b0;
        end else begin
            start_freq_reg  <= start_freq_next;
            detect_freq_reg <= detect_freq_next;
            band_pct_reg    <= band_pct_next;
            config_reg      <= config_next;
            irq_status_reg  <= irq_status_next;
            irq_mask_reg    <= irq_mask_next;
            rdata_reg       <= rdata_next;
            ack_reg         <= ack_next;
            irq_reg         <= irq_next;
        end
    end

    // Phase accumulator toggles the meter line twice per pulse
    always_comb begin
        // Widen before the product: full scale does not fit in 30 bits
        meter_inc = 40'(config_reg[`CFG_METER_SEL_BIT] ? drive_i.set_freq
                                                       : drive_i.out_freq)
                    * 40'(TOGGLE_STEP);                                 // [RULE11]
        if (config_reg[`CFG_OC_PULSE_BIT] && meter_inc > OC_MAX_INC) begin
            meter_inc = OC_MAX_INC;                                     // [RULE13]
        end
        meter_sum = meter_acc_reg + meter_inc;
        if (drive_i.drive_reset) begin
            meter_acc_next = 40'h00_0000_0000;                          // [RULE12]
            meter_next     = 1'b0;
        end else if (meter_sum >= METER_WRAP) begin
            meter_acc_next = meter_sum - METER_WRAP;
            meter_next     = !meter_reg;
        end else begin
            meter_acc_next = meter_sum;
            meter_next     = meter_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meter_acc_reg <= 40'h00_0000_0000;
            meter_reg     <= 1'b0;
        end else begin
            meter_acc_reg <= meter_acc_next;
            meter_reg     <= meter_next;
        end
    end

    assign dat_o                     = rdata_reg;
    assign ack_o                     = ack_reg;
    assign irq_o                     = irq_reg;
    // Low means transistor conducting
    assign running_flag_n_o          = pins_n_reg[0];                   // [RULE10]
    assign up_to_speed_flag_n_o      = pins_n_reg[1];                   // [RULE10]
    assign overload_warning_flag_n_o = pins_n_reg[2];                   // [RULE10]
    assign power_failure_flag_n_o    = pins_n_reg[3];                   // [RULE10]
    assign freq_detect_flag_n_o      = pins_n_reg[4];                   // [RULE10]
    assign fault_relay_no_contact_o  = flags_reg.fault;                 // [RULE2]
    assign fault_relay_nc_contact_o  = relay_nc_reg;                    // [RULE2]
    assign meter_pulse_out_o         = meter_reg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_relay_fault: assert property (                                    // [RULE1]
        !rst_i && drive_i.prot_tripped && drive_i.output_off |=> !fault_relay_nc_contact_o)
        else $error("Relay not in fault position after trip");
    a_relay_exclusive: assert property (                                // [RULE2]
        fault_relay_no_contact_o != fault_relay_nc_contact_o)
        else $error("Relay contact paths not complementary");
    a_run_start: assert property (                                      // [RULE3]
        drive_i.out_freq >= start_freq_reg && !drive_i.stopped && !drive_i.dc_brake
        |=> !running_flag_n_o)
        else $error("Running flag missed at starting frequency");
    a_run_brake: assert property (                                      // [RULE4]
        drive_i.stopped || drive_i.dc_brake |=> running_flag_n_o)
        else $error("Running flag on while stopped or braking");
    a_speed_ramp: assert property (                                     // [RULE6]
        drive_i.accel || drive_i.decel || drive_i.stopped |=> up_to_speed_flag_n_o)
        else $error("Up-to-speed flag on during ramp or stop");
    a_speed_band: assert property (                                     // [RULE5]
        !drive_i.accel && !drive_i.decel && !drive_i.stopped
        && drive_i.out_freq == drive_i.set_freq |=> !up_to_speed_flag_n_o)
        else $error("Up-to-speed flag off at set frequency");
    a_overload_follow: assert property (                                // [RULE7]
        !rst_i |=> overload_warning_flag_n_o == !$past(drive_i.stall_active))
        else $error("Overload flag does not follow stall prevention");
    a_power_fail: assert property (                                     // [RULE8]
        drive_i.inst_power_fail || drive_i.undervoltage |=> !power_failure_flag_n_o)
        else $error("Power failure flag missed");
    a_detect_thresh: assert property (                                  // [RULE9]
        drive_i.out_freq < detect_freq_reg |=> freq_detect_flag_n_o)
        else $error("Frequency detect on below threshold");
    a_meter_reset: assert property (                                    // [RULE12]
        drive_i.drive_reset [*2] |-> !meter_pulse_out_o)
        else $error("Meter pulses during drive reset");
    a_meter_limit: assert property (                                    // [RULE13]
        config_reg[`CFG_OC_PULSE_BIT] |-> meter_inc <= OC_MAX_INC)
        else $error("Open-collector pulse rate over limit");
    a_flags_latency: assert property (                                  // [RULE14]
        !rst_i |=> flags_reg == $past(flags_next))
        else $error("Flags not registered in one cycle");
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("Ack held for more than one cycle");

    c_fault_trip: cover property (!fault_relay_no_contact_o ##1 fault_relay_no_contact_o);
    c_meter_toggle: cover property ($rose(meter_pulse_out_o));
    c_irq_raise: cover property ($rose(irq_o));
    c_speed_reach: cover property ($fell(up_to_speed_flag_n_o));
    c_power_fail: cover property ($fell(power_failure_flag_n_o));

endmodule : drive_status_outputs

/* test/meter_reader.sv */
/*
 * Meter-side model: counts meter pulses (rising edges) while gated.
 * Assumes a meter line synchronous to clk_i.
 */
`timescale 1ns/1ps

module meter_reader (
    input  wire logic        clk_i,
    input  wire logic        clr_i,
    input  wire logic        gate_i,
    input  wire logic        meter_i,
    output logic      [15:0] count_o
);
    logic        meter_q_reg;
    logic [15:0] count_reg;
    logic [15:0] count_next;

    always_comb begin
        count_next = count_reg;
        if (clr_i) begin
            count_next = 16'h0000;
        end else if (gate_i && meter_i && !meter_q_reg) begin
            count_next = count_reg + 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        meter_q_reg <= meter_i;
        count_reg   <= count_next;
    end

    assign count_o = count_reg;
endmodule : meter_reader

/* test/tb_top.sv */
/*
 * Self-checking bench: flag table, thresholds, registers, interrupt, meter.
 * Assumes the meter_reader model on the meter output.
 */
`timescale 1ns/1ps

module tb_top
    import drive_status_pkg::*;
;
    // Raised pulse scale keeps meter windows short
    localparam int PULSES = 1440000;
    logic            clk_i = 1'b0;
    logic            rst_i = 1'b1;
    drive_state_type drive_i = drive_state_type'({32'h0, 10'h0A6});
    logic            cyc_i = 1'b0;
    logic            stb_i = 1'b0;
    logic            we_i = 1'b0;
    logic [7:0]      adr_i = 8'h00;
    logic [31:0]     dat_i = 32'h0;
    logic [31:0]     dat_o;
    logic            ack_o;
    logic            irq_o;
    logic [6:0]      outs;
    logic            meter;
    logic            clr = 1'b0;
    logic            gate = 1'b0;
    logic [15:0]     count;
    logic [31:0]     r;
    int              num_errors = 0;
    int              checked = 0;
    logic [48:0]     rows [15] = '{
        {16'h0032, 16'h0032, 10'h000, 7'b0011101}, {16'h0031, 16'h1000, 10'h000, 7'b1111101},
        {16'h1770, 16'h1770, 10'h080, 7'b1111001}, {16'h1770, 16'h1770, 10'h040, 7'b1011001},
        {16'h1000, 16'h1000, 10'h200, 7'b0111101}, {16'h1000, 16'h1000, 10'h100, 7'b0111101},
        {16'h044C, 16'h03E8, 10'h000, 7'b0011101}, {16'h044D, 16'h03E8, 10'h000, 7'b0111101},
        {16'h1000, 16'h1000, 10'h020, 7'b0001101}, {16'h1000, 16'h1000, 10'h010, 7'b0010101},
        {16'h1000, 16'h1000, 10'h008, 7'b0010101}, {16'h1000, 16'h1000, 10'h004, 7'b0011101},
        {16'h1000, 16'h1000, 10'h002, 7'b0011101}, {16'h0000, 16'h0000, 10'h086, 7'b1111110},
        {16'h176F, 16'h176F, 10'h000, 7'b0011101}};

    always #4 clk_i = ~clk_i;

    drive_status_outputs #(.PULSES_AT_REF(PULSES)) drive_status_outputs_inst (
        .clk_i(clk_i), .rst_i(rst_i), .drive_i(drive_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .irq_o(irq_o), .running_flag_n_o(outs[6]),
        .up_to_speed_flag_n_o(outs[5]), .overload_warning_flag_n_o(outs[4]),
        .power_failure_flag_n_o(outs[3]), .freq_detect_flag_n_o(outs[2]),
        .fault_relay_no_contact_o(outs[1]), .fault_relay_nc_contact_o(outs[0]),
        .meter_pulse_out_o(meter));

    meter_reader meter_reader_inst (
        .clk_i(clk_i), .clr_i(clr), .gate_i(gate), .meter_i(meter), .count_o(count));

    task automatic close_out();
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic wb(input logic wr, input logic [7:0] adr, input logic [31:0] wdat);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= wr;
        adr_i <= adr;
        dat_i <= wdat;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        r = dat_o;
        check({31'h0, n < 20}, 32'h1, "bus answer");
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask : wb

    task automatic rdc(input logic [7:0] adr, input logic [31:0] exp, input string msg);
        wb(1'b0, adr, 32'h0);
        check(r, exp, msg);
    endtask : rdc

    // Flag outputs land on the edge that samples drive_i, one edge after it is driven
    task automatic apply(input logic [41:0] d, input logic [6:0] exp);
        @(posedge clk_i);
        drive_i <= drive_state_type'(d);
        @(posedge clk_i);
        @(negedge clk_i);
        check(outs[6], exp[6], "running");
        check(outs[5], exp[5], "up to speed");
        check(outs[4], exp[4], "overload");
        check(outs[3], exp[3], "power fail");
        check(outs[2], exp[2], "freq detect");
        check(outs[1:0], exp[1:0], "fault relay");
    endtask : apply

    task automatic meas(input logic [41:0] d, input int n, input int lo, input int hi);
        @(posedge clk_i);
        drive_i <= drive_state_type'(d);
        clr <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
        gate <= 1'b1;
        repeat (n) @(posedge clk_i);
        gate <= 1'b0;
        @(negedge clk_i);
        check({31'h0, count >= lo && count <= hi}, 32'h1, "meter pulse count");
    endtask : meas

    initial begin
        repeat (70000) @(posedge clk_i);
        num_errors++;
        close_out();
    end

    initial begin
        repeat (4) @(posedge clk_i);
        check({outs, meter, ack_o, irq_o}, {7'b1111101, 3'b000}, "outputs in reset");
        rst_i <= 1'b0;
        rdc(8'h00, 32'h0032, "start freq reset");
        rdc(8'h04, 32'h1770, "detect freq reset");
        rdc(8'h08, 32'h000A, "band reset");
        rdc(8'h0C, 32'h0, "config reset");
        rdc(8'h18, 32'h0, "mask reset");
        wb(1'b1, 8'h40, 32'hFFFFFFFF);
        rdc(8'h40, 32'h0, "unmapped read");
        for (int i = 0; i < 15; i++) begin
            apply(rows[i][48:7], rows[i][6:0]);
        end
        // Moved thresholds and a wider band
        wb(1'b1, 8'h00, 32'h0100);
        wb(1'b1, 8'h04, 32'h0200);
        wb(1'b1, 8'h08, 32'h0014);
        apply({16'h00FF, 16'h00FF, 10'h000}, 7'b1011101);
        apply({16'h0200, 16'h01B0, 10'h000}, 7'b0011001);
        apply({16'h01FF, 16'h01FF, 10'h000}, 7'b0011101);
        apply({16'h1000, 16'h1000, 10'h020}, 7'b0001001);
        rdc(8'h10, 32'h0017, "flags register");
        apply({16'h1000, 16'h1000, 10'h000}, 7'b0011001);
        wb(1'b1, 8'h14, 32'h000F);
        rdc(8'h14, 32'h0, "status cleared");
        wb(1'b1, 8'h18, 32'h0004);
        apply({16'h1000, 16'h1000, 10'h020}, 7'b0001001);
        @(negedge clk_i);
        check(irq_o, 1'b1, "irq on overload");
        apply({16'h1000, 16'h1000, 10'h010}, 7'b0010001);
        rdc(8'h14, 32'h0006, "sticky status");
        check(irq_o, 1'b1, "irq held");
        wb(1'b1, 8'h14, 32'h0004);
        repeat (2) @(negedge clk_i);
        check(irq_o, 1'b0, "masked power fail");
        rdc(8'h14, 32'h0002, "status after clear");
        // 60 Hz scaled: 115.2 pulses in 10000 cycles
        wb(1'b1, 8'h0C, 32'h0);
        meas({16'h1770, 16'h0000, 10'h000}, 10000, 114, 117);
        meas({16'h0BB8, 16'h0000, 10'h000}, 10000, 56, 59);
        wb(1'b1, 8'h0C, 32'h1);
        meas({16'h0000, 16'h1770, 10'h000}, 10000, 114, 117);
        wb(1'b1, 8'h0C, 32'h2);
        meas({16'h1770, 16'h0000, 10'h000}, 20000, 7, 9);
        wb(1'b1, 8'h0C, 32'h0);
        meas({16'h1770, 16'h0000, 10'h001}, 2000, 0, 0);
        check(meter, 1'b0, "meter idle in reset");
        close_out();
    end
endmodule : tb_top
